// ---- hw/calib_loader_defines.svh ----
// Address map, field indices and timing constants of the calibration loader
`ifndef CALIB_LOADER_DEFINES_SVH
`define CALIB_LOADER_DEFINES_SVH

// Nonvolatile array shape
`define NV_ADDR_W 10
`define NV_DATA_W 8
`define NV_DEPTH 768
`define NV_PAGE_BYTES 64
`define NV_PAGES 12
`define NV_PAGE_W 4

// Lock code values
`define LOCK_ALL_ONES 8'hff
`define LOCK_ALL_ZEROS 8'h00

// Fixed word locations, low byte at the even address
`define SETUP_ADDR 10'h160
`define OTC_ADDR 10'h164
`define STC_ADDR 10'h168

// Lookup tables
`define OFS_TBL_BASE 10'h000
`define SPAN_LO_BASE 10'h200
`define SPAN_HI_BASE 10'h1a0
`define SPAN_SPLIT 8'h80
`define PTR_MAX 8'haf

// User byte region, never loaded into a register
`define USER_FIRST 10'h16c
`define USER_LAST 10'h19f

// Calibration register bank
`define CAL_REG_W 16
`define CAL_REG_NUM 5
`define CAL_IDX_W 3
`define REG_SETUP 3'h0
`define REG_OTC 3'h1
`define REG_STC 3'h2
`define REG_OFS 3'h3
`define REG_SPAN 3'h4
`define REG_LAST 3'h4

// Refresh timing
`define REFRESH_NS 1000000
`define CLK_PERIOD_NS 40
`define TIMER_W 16

`endif

// ---- hw/calib_loader_pkg.sv ----
// Types shared by the calibration loader and its byte reader
package calib_loader_pkg;
`include "calib_loader_defines.svh"

    typedef logic [`NV_ADDR_W-1:0] nv_addr_t;
    typedef logic [`CAL_REG_W-1:0] cal_word_t;
    typedef logic [`CAL_REG_NUM-1:0][`CAL_REG_W-1:0] cal_bank_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b00,
        RD_LOW = 2'b01,
        RD_HIGH = 2'b10
    } rd_phase_t;

    typedef struct packed {
        rd_phase_t phase;
        nv_addr_t addr;
        logic rd;
        logic [`NV_DATA_W-1:0] lo;
        cal_word_t word;
        logic done;
    } rd_state_t;

    typedef enum logic [2:0] {
        LD_RESET = 3'b000,
        LD_DECIDE = 3'b001,
        LD_IDLE = 3'b010,
        LD_ISSUE = 3'b011,
        LD_WAIT = 3'b100
    } ld_state_t;

    typedef enum logic [1:0] {
        MODE_NONE = 2'b00,
        MODE_NORMAL = 2'b01,
        MODE_CALIB = 2'b10
    } op_mode_t;

    typedef struct packed {
        ld_state_t st;
        op_mode_t mode;
        logic [`CAL_IDX_W-1:0] idx;
        logic [7:0] ptr;
        logic [`TIMER_W-1:0] timer;
        logic pend;
        logic busy;
        logic req;
        nv_addr_t req_addr;
        logic erase;
        logic [`NV_PAGE_W-1:0] erase_page;
        cal_bank_t regs;
    } ld_state_s_t;
endpackage

// ---- hw/nv_word_reader.sv ----
// Two-byte word fetch from the byte-wide nonvolatile array
`timescale 1ns/1ps
module nv_word_reader
    import calib_loader_pkg::*;
(
    input wire logic clock_in,              // System clock
    input wire logic rst_b_in,              // Async reset, active low
    input wire logic req_in,                // Start a word fetch
    input wire nv_addr_t addr_in,           // Even byte address of word
    input wire logic [7:0] nv_data_in,      // Byte from array
    input wire logic nv_ack_in,             // Byte valid this cycle
    output nv_addr_t nv_addr_out,           // Byte address to array
    output logic nv_rd_out,                 // Read request, held to ack
    output cal_word_t word_out,             // Assembled word
    output logic done_out                   // Word ready, one cycle
);
    rd_state_t q;
    rd_state_t d;

    // Low byte first, then high byte; word published only when whole
    always_comb begin
        d = q;
        d.done = 1'b0;
        case (q.phase)
            RD_IDLE: begin
                if (req_in) begin
                    d.addr = {addr_in[`NV_ADDR_W-1:1], 1'b0};
                    d.rd = 1'b1;
                    d.phase = RD_LOW;
                end
            end
            RD_LOW: begin
                if (nv_ack_in) begin
                    d.lo = nv_data_in;
                    d.addr = {q.addr[`NV_ADDR_W-1:1], 1'b1};
                    d.phase = RD_HIGH;
                end
            end
            RD_HIGH: begin
                if (nv_ack_in) begin
                    d.word = {nv_data_in, q.lo};
                    d.done = 1'b1;
                    d.rd = 1'b0;
                    d.phase = RD_IDLE;
                end
            end
            default: begin
                d.rd = 1'b0;
                d.phase = RD_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from state
    assign nv_addr_out = q.addr;
    assign nv_rd_out = q.rd;
    assign word_out = q.word;
    assign done_out = q.done;
endmodule

// ---- hw/calibration_register_loader.sv ----
// Calibration register loader: array fetch, refresh timer, serial writes
//
// Summary of operation
// - Five 16-bit calibration registers, loaded from array or serial side.
// - Auto loading only when lock byte is all ones and unlock low.
// - After reset, normal mode loads setup word and both tempco registers.
// - Offset and span trim come from entries chosen by thermal pointer.
// - Every 1ms in normal mode all five registers reload.
// - Lock zero or unlock high: no auto load, serial writes only.
// - Array is 768 bytes addressed by a 10-bit byte address.
// - Twelve 64-byte pages; erasing one page leaves the others alone.
// - Offset trim entry n sits at bytes 2n and 2n+1.
// - Span trim below 0x80 from upper region, else from lower region.
// - Words are low byte at even address, high byte next odd.
// - Setup, offset tempco, span tempco fetched at fixed even addresses.
// - The 52 user bytes never reach any calibration register.
// - Thermal pointer is 8 bits, refreshed once every 1ms.
// - Pointer above last entry clamps to last entry, never wraps.
`timescale 1ns/1ps
module calibration_register_loader
    import calib_loader_pkg::*;
#(
    parameter int unsigned REFRESH_CYCLES = `REFRESH_NS / `CLK_PERIOD_NS
)
(
    input wire logic clock_in,                  // 25 MHz system clock
    input wire logic rst_b_in,                  // Power-on reset, low
    input wire logic [7:0] lock_code_byte_in,   // Lock code byte
    input wire logic unlock_in,                 // Unlock pin, high unlocks
    input wire logic [7:0] thermal_ptr_in,      // Temperature conversion
    input wire logic [7:0] nv_data_in,          // Byte from array
    input wire logic nv_ack_in,                 // Byte valid this cycle
    input wire logic ser_wr_in,                 // Serial register write
    input wire logic [2:0] ser_sel_in,          // Target register index
    input wire cal_word_t ser_data_in,          // Serial write data
    input wire logic ser_erase_in,              // Serial page erase
    input wire logic [3:0] ser_page_in,         // Page to erase
    output nv_addr_t nv_addr_out,               // Byte address to array
    output logic nv_rd_out,                     // Byte read request
    output logic nv_erase_out,                  // Page erase pulse
    output logic [3:0] nv_erase_page_out,       // Page being erased
    output cal_word_t setup_word_out,           // Setup word register
    output cal_word_t offset_tempco_reg_out,    // Offset tempco register
    output cal_word_t span_tempco_reg_out,      // Span tempco register
    output cal_word_t offset_trim_reg_out,      // Offset trim register
    output cal_word_t span_trim_reg_out,        // Span trim register
    output logic normal_mode_out,               // Normal operation active
    output logic load_busy_out                  // Array load in progress
);
    localparam logic [`TIMER_W-1:0] TIMER_LAST =
        `TIMER_W'(REFRESH_CYCLES - 1);
    localparam logic [`NV_PAGE_W-1:0] PAGE_COUNT =
        `NV_PAGE_W'(`NV_PAGES);

    ld_state_s_t q;
    ld_state_s_t d;

    cal_word_t rd_word;
    logic rd_done;
    logic tick;
    logic normal_req;
    logic [`CAL_REG_NUM-1:0] ser_we;
    logic [`CAL_REG_NUM-1:0] nv_we;

    // Pointer clamp: values past the last entry stay on the last entry
    function automatic logic [7:0] clamp_ptr(input logic [7:0] p);
        logic [7:0] r;
        r = p;
        if (p > `PTR_MAX) begin
            r = `PTR_MAX;
        end
        return r;
    endfunction

    // Byte address of the low byte for each register in the bank
    function automatic nv_addr_t word_addr(
        input logic [`CAL_IDX_W-1:0] idx,
        input logic [7:0] p
    );
        nv_addr_t a;
        logic [7:0] hi_off;
        a = `SETUP_ADDR;
        hi_off = p - `SPAN_SPLIT;
        case (idx)
            `REG_SETUP: begin
                a = `SETUP_ADDR;
            end
            `REG_OTC: begin
                a = `OTC_ADDR;
            end
            `REG_STC: begin
                a = `STC_ADDR;
            end
            `REG_OFS: begin
                a = `OFS_TBL_BASE + {1'b0, p, 1'b0};
            end
            `REG_SPAN: begin
                if (p < `SPAN_SPLIT) begin
                    a = `SPAN_LO_BASE + {1'b0, p, 1'b0};
                end else begin
                    a = `SPAN_HI_BASE + {1'b0, hi_off, 1'b0};
                end
            end
            default: begin
                a = `SETUP_ADDR;
            end
        endcase
        return a;
    endfunction

    // Two-byte word fetch engine
    nv_word_reader u_reader (
        .clock_in(clock_in),
        .rst_b_in(rst_b_in),
        .req_in(q.req),
        .addr_in(q.req_addr),
        .nv_data_in(nv_data_in),
        .nv_ack_in(nv_ack_in),
        .nv_addr_out(nv_addr_out),
        .nv_rd_out(nv_rd_out),
        .word_out(rd_word),
        .done_out(rd_done)
    );

    // Lock decision from lock byte and unlock pin
    assign normal_req = (lock_code_byte_in == `LOCK_ALL_ONES) && !unlock_in;

    // Refresh period boundary
    assign tick = (q.mode == MODE_NORMAL) && (q.timer == TIMER_LAST);

    // Per-register write enables from the serial side and the fetch engine
    genvar gi;
    generate
        for (gi = 0; gi < `CAL_REG_NUM; gi++) begin : g_we
            assign ser_we[gi] = ser_wr_in && (q.mode == MODE_CALIB) &&
                (ser_sel_in == `CAL_IDX_W'(gi));
            assign nv_we[gi] = rd_done && (q.st == LD_WAIT) &&
                (q.idx == `CAL_IDX_W'(gi));
        end
    endgenerate

    // Next-state logic of the loader
    always_comb begin
        d = q;
        d.req = 1'b0;
        d.erase = 1'b0;

        // Free-running 1ms timer in normal mode
        if (q.mode == MODE_NORMAL) begin
            if (tick) begin
                d.timer = '0;
                d.pend = 1'b1;
            end else begin
                d.timer = q.timer + `TIMER_W'(1);
            end
        end

        case (q.st)
            // One cycle after reset release before sampling the lock
            LD_RESET: begin
                d.st = LD_DECIDE;
            end
            // Catch the mode once power-on reset is over
            LD_DECIDE: begin
                if (normal_req) begin
                    d.mode = MODE_NORMAL;
                    d.ptr = clamp_ptr(thermal_ptr_in);
                    d.idx = `REG_SETUP;
                    d.busy = 1'b1;
                    d.timer = '0;
                    d.st = LD_ISSUE;
                end else begin
                    d.mode = MODE_CALIB;
                    d.st = LD_IDLE;
                end
            end
            // Wait for the next refresh, or serve serial requests
            LD_IDLE: begin
                if (q.mode == MODE_NORMAL && (q.pend || tick)) begin
                    d.pend = 1'b0;
                    d.ptr = clamp_ptr(thermal_ptr_in);
                    d.idx = `REG_SETUP;
                    d.busy = 1'b1;
                    d.st = LD_ISSUE;
                end
            end
            // Hand one word address to the fetch engine
            LD_ISSUE: begin
                d.req = 1'b1;
                d.req_addr = word_addr(q.idx, q.ptr);
                d.st = LD_WAIT;
            end
            // Wait for the whole word, then step to the next register
            LD_WAIT: begin
                if (rd_done) begin
                    if (q.idx == `REG_LAST) begin
                        d.busy = 1'b0;
                        d.st = LD_IDLE;
                    end else begin
                        d.idx = q.idx + `CAL_IDX_W'(1);
                        d.st = LD_ISSUE;
                    end
                end
            end
            default: begin
                d.st = LD_RESET;
            end
        endcase

        // Register bank update, whole words only
        for (int i = 0; i < `CAL_REG_NUM; i++) begin
            if (nv_we[i]) begin
                d.regs[i] = rd_word;
            end else if (ser_we[i]) begin
                d.regs[i] = ser_data_in;
            end
        end

        // Page erase only for pages that exist, in calibration mode
        if (ser_erase_in && q.mode == MODE_CALIB &&
            ser_page_in < PAGE_COUNT) begin
            d.erase = 1'b1;
            d.erase_page = ser_page_in;
        end
    end

    // State register
    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from state
    assign setup_word_out = q.regs[`REG_SETUP];
    assign offset_tempco_reg_out = q.regs[`REG_OTC];
    assign span_tempco_reg_out = q.regs[`REG_STC];
    assign offset_trim_reg_out = q.regs[`REG_OFS];
    assign span_trim_reg_out = q.regs[`REG_SPAN];
    assign normal_mode_out = (q.mode == MODE_NORMAL);
    assign load_busy_out = q.busy;
    assign nv_erase_out = q.erase;
    assign nv_erase_page_out = q.erase_page;
endmodule

// ---- sim/nv_array_model.sv ----
// Byte-wide nonvolatile array model with page erase
`timescale 1ns/1ps
module nv_array_model
    import calib_loader_pkg::*;
(
    input wire logic clock_in,       // Clock
    input wire nv_addr_t addr_in,    // Byte address
    input wire logic rd_in,          // Read request
    input wire logic erase_in,       // Page erase pulse
    input wire logic [3:0] page_in,  // Page to erase
    input wire logic slow_in,        // Add wait cycles
    output logic [7:0] data_out,     // Byte out
    output logic ack_out             // Byte valid
);
    logic [7:0] mem [768];
    logic [1:0] cnt = 2'h0;
    // Address pattern, distinct per byte within each 256-byte block
    initial begin
        data_out = 8'h00;
        ack_out = 1'b0;
        for (int a = 0; a < 768; a++) begin
            mem[a] = a[7:0] ^ {a[9:8], 6'h2a};
        end
    end
    // Answer reads; idle data toggles; erase a page
    always @(posedge clock_in) begin
        ack_out <= 1'b0;
        data_out <= ~data_out;
        cnt <= 2'h0;
        if (erase_in && page_in < 4'hc) begin
            for (int i = 0; i < 64; i++) begin
                mem[int'({page_in, 6'h00}) + i] <= 8'hff;
            end
        end
        if (rd_in && !ack_out) begin
            cnt <= cnt + 2'h1;
            if (cnt >= (slow_in ? 2'h3 : 2'h0)) begin
                ack_out <= 1'b1;
                data_out <= mem[addr_in];
                cnt <= 2'h0;
            end
        end
    end
endmodule

// ---- sim/cal_loader_chk.sv ----
// Port checker for the calibration register loader
`timescale 1ns/1ps
module cal_loader_chk
    import calib_loader_pkg::*;
(
    input wire logic clock_in,               // Clock
    input wire logic rst_b_in,               // Reset, active low
    input wire logic ser_wr_in,              // Write strobe
    input wire logic [2:0] ser_sel_in,       // Register index
    input wire cal_word_t ser_data_in,       // Write data
    input wire logic ser_erase_in,           // Erase strobe
    input wire logic [3:0] ser_page_in,      // Erase page
    input wire logic nv_ack_in,              // Byte valid
    input wire nv_addr_t nv_addr_out,        // Byte address
    input wire logic nv_rd_out,              // Read request
    input wire logic nv_erase_out,           // Erase pulse
    input wire logic [3:0] nv_erase_page_out, // Erased page
    input wire cal_word_t offset_trim_reg_out, // Offset trim
    input wire logic normal_mode_out         // Normal mode
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    // Array handshake and addressing
    chk_rd_hold: assert property (nv_rd_out && !nv_ack_in |=>
        nv_rd_out && $stable(nv_addr_out)) else $error("read dropped");
    chk_low_to_odd: assert property (nv_rd_out && nv_ack_in &&
        !nv_addr_out[0] |=> nv_rd_out &&
        nv_addr_out == $past(nv_addr_out) + 10'h1) else $error("no odd");
    chk_addr_range: assert property (nv_rd_out |->
        nv_addr_out < 10'h300) else $error("address past array");
    chk_user_skip: assert property (nv_rd_out |->
        (nv_addr_out < 10'h16c || nv_addr_out > 10'h19f))
        else $error("user byte read");
    chk_calib_noread: assert property (!normal_mode_out |->
        !nv_rd_out) else $error("read outside normal mode");
    chk_word_whole: assert property (normal_mode_out &&
        $changed(offset_trim_reg_out) |-> !nv_rd_out &&
        ($past(nv_ack_in) || $past(nv_ack_in, 2) || $past(nv_ack_in, 3)))
        else $error("trim changed mid word");
    // Serial side
    chk_erase_lock: assert property (normal_mode_out |->
        !nv_erase_out) else $error("erase in normal mode");
    chk_erase_map: assert property (ser_erase_in && !normal_mode_out
        && ser_page_in < 4'hc |=> nv_erase_out &&
        nv_erase_page_out == $past(ser_page_in)) else $error("erase lost");
    chk_erase_bad: assert property (ser_erase_in &&
        ser_page_in > 4'hb |=> !nv_erase_out) else $error("bad page");
    chk_ser_write: assert property (ser_wr_in && !normal_mode_out &&
        ser_sel_in == 3'h3 |=> offset_trim_reg_out == $past(ser_data_in))
        else $error("serial write lost");
    cov_high_ack: cover property (nv_rd_out && nv_ack_in && nv_addr_out[0]);
    cov_erase: cover property (nv_erase_out);
    cov_ser_wr: cover property (ser_wr_in && !normal_mode_out);
endmodule

bind calibration_register_loader cal_loader_chk u_chk (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .ser_wr_in(ser_wr_in),
    .ser_sel_in(ser_sel_in), .ser_data_in(ser_data_in),
    .ser_erase_in(ser_erase_in), .ser_page_in(ser_page_in),
    .nv_ack_in(nv_ack_in), .nv_addr_out(nv_addr_out),
    .nv_rd_out(nv_rd_out), .nv_erase_out(nv_erase_out),
    .nv_erase_page_out(nv_erase_page_out),
    .offset_trim_reg_out(offset_trim_reg_out),
    .normal_mode_out(normal_mode_out));

// ---- sim/testbench.sv ----
// Testbench for the calibration register loader
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
    total_checks++; \
    if ((g) !== (e)) begin \
        bad_count++; \
        $display("[ERR] %s exp %h got %h", n, e, g); \
    end \
end
module testbench;
    import calib_loader_pkg::*;
    localparam int RC = 200;
    logic clock_in = 1'b0, rst_b_in = 1'b0, unlock_in = 1'b0, slow = 1'b0;
    logic ser_wr_in = 1'b0, ser_erase_in = 1'b0, nv_ack_in, nv_rd_out;
    logic [7:0] lock_code_byte_in = 8'hff, thermal_ptr_in = 8'h10;
    logic [7:0] nv_data_in;
    logic [2:0] ser_sel_in = 3'h0;
    logic [3:0] ser_page_in = 4'h0, nv_erase_page_out;
    cal_word_t ser_data_in = 16'h0000, setup_w, otc_w, stc_w, ofs_w, span_w;
    nv_addr_t nv_addr_out;
    logic nv_erase_out, normal_mode_out, load_busy_out;
    int bad_count = 0, total_checks = 0, cyc = 0;

    calibration_register_loader #(.REFRESH_CYCLES(RC)) dut (
        .clock_in(clock_in), .rst_b_in(rst_b_in),
        .lock_code_byte_in(lock_code_byte_in), .unlock_in(unlock_in),
        .thermal_ptr_in(thermal_ptr_in), .nv_data_in(nv_data_in),
        .nv_ack_in(nv_ack_in), .ser_wr_in(ser_wr_in),
        .ser_sel_in(ser_sel_in), .ser_data_in(ser_data_in),
        .ser_erase_in(ser_erase_in), .ser_page_in(ser_page_in),
        .nv_addr_out(nv_addr_out), .nv_rd_out(nv_rd_out),
        .nv_erase_out(nv_erase_out), .nv_erase_page_out(nv_erase_page_out),
        .setup_word_out(setup_w), .offset_tempco_reg_out(otc_w),
        .span_tempco_reg_out(stc_w), .offset_trim_reg_out(ofs_w),
        .span_trim_reg_out(span_w), .normal_mode_out(normal_mode_out),
        .load_busy_out(load_busy_out));
    nv_array_model u_nv (.clock_in(clock_in), .addr_in(nv_addr_out),
        .rd_in(nv_rd_out), .erase_in(nv_erase_out),
        .page_in(nv_erase_page_out), .slow_in(slow),
        .data_out(nv_data_in), .ack_out(nv_ack_in));

    // Clock and hang guard
    initial begin
        forever #20 clock_in = ~clock_in;
    end
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 8000) begin
            bad_count++;
            stop_test();
        end
    end

    function automatic cal_word_t ew(int a);
        return {a[7:0] ^ 8'h01 ^ {a[9:8], 6'h2a}, a[7:0] ^ {a[9:8], 6'h2a}};
    endfunction
    task automatic check_regs(int p);
        int q;
        int sa;
        q = (p > 'haf) ? 'haf : p;
        sa = (q < 'h80) ? 'h200 + 2 * q : 'h1a0 + 2 * (q - 'h80);
        `CHK("setup", ew('h160), setup_w)
        `CHK("otc", ew('h164), otc_w)
        `CHK("stc", ew('h168), stc_w)
        `CHK("ofs", ew(2 * q), ofs_w)
        `CHK("span", ew(sa), span_w)
    endtask
    task automatic do_reset(logic [7:0] lk, logic ul);
        @(negedge clock_in);
        rst_b_in = 1'b0;
        lock_code_byte_in = lk;
        unlock_in = ul;
        repeat (16) @(negedge clock_in);
        rst_b_in = 1'b1;
    endtask
    // Wait for a load to start and finish, bounded
    task automatic wait_load;
        repeat (2 * RC) if (!load_busy_out) @(negedge clock_in);
        repeat (RC) if (load_busy_out) @(negedge clock_in);
    endtask

    task automatic t_boot;
        do_reset(8'hff, 1'b0);
        wait_load();
        `CHK("mode", 1'b1, normal_mode_out)
        `CHK("busy", 1'b0, load_busy_out)
        check_regs(8'h10);
        $display("test boot done");
    endtask
    task automatic t_refresh;
        logic [7:0] ptrs [6] = '{8'h00, 8'h7f, 8'h80, 8'h9f, 8'haf, 8'hc0};
        for (int i = 0; i < 6; i++) begin
            thermal_ptr_in = ptrs[i];
            slow = i[0];
            wait_load();
            check_regs(ptrs[i]);
        end
        $display("test refresh done");
    endtask
    task automatic t_refused;
        ser_wr_in = 1'b1;
        ser_sel_in = 3'h3;
        ser_data_in = 16'h1234;
        ser_erase_in = 1'b1;
        ser_page_in = 4'h1;
        @(negedge clock_in);
        ser_wr_in = 1'b0;
        ser_erase_in = 1'b0;
        `CHK("erase", 1'b0, nv_erase_out)
        @(negedge clock_in);
        `CHK("ofs", ew(2 * 'haf), ofs_w)
        $display("test refused done");
    endtask
    task automatic t_calib;
        int rds;
        cal_word_t got [5];
        rds = 0;
        do_reset(8'h00, 1'b0);
        repeat (RC + 50) begin
            @(negedge clock_in);
            rds += int'(nv_rd_out);
        end
        `CHK("reads", 0, rds)
        `CHK("setup", 16'h0000, setup_w)
        for (int s = 0; s < 6; s++) begin
            ser_wr_in = 1'b1;
            ser_sel_in = s[2:0];
            ser_data_in = cal_word_t'(16'ha5c0 + s);
            @(negedge clock_in);
        end
        ser_wr_in = 1'b0;
        got = '{setup_w, otc_w, stc_w, ofs_w, span_w};
        for (int k = 0; k < 5; k++) begin
            `CHK("reg", cal_word_t'(16'ha5c0 + k), got[k])
        end
        ser_erase_in = 1'b1;
        ser_page_in = 4'h5;
        @(negedge clock_in);
        ser_page_in = 4'hc;
        `CHK("erase", 1'b1, nv_erase_out)
        `CHK("page", 4'h5, nv_erase_page_out)
        @(negedge clock_in);
        ser_erase_in = 1'b0;
        `CHK("erase12", 1'b0, nv_erase_out)
        $display("test calib done");
    endtask
    task automatic t_unlock;
        do_reset(8'hff, 1'b1);
        repeat (50) @(negedge clock_in);
        `CHK("mode_ul", 1'b0, normal_mode_out)
        do_reset(8'h5a, 1'b0);
        repeat (50) @(negedge clock_in);
        `CHK("mode_5a", 1'b0, normal_mode_out)
        $display("test unlock done");
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        t_boot();
        t_refresh();
        t_refused();
        t_calib();
        t_unlock();
        stop_test();
    end
endmodule
